// *** rtl/mii_phy_pkg.sv ***
package mii_phy_pkg;

   // ==========================================================
   // Clock and link rates
   localparam int CLK_HZ     = 100_000_000;
   localparam int F100_HZ    = 25_000_000;
   localparam int F10N_HZ    = 2_500_000;
   localparam int F10S_HZ    = 10_000_000;
   localparam logic [5:0] HALF_100 = 6'(CLK_HZ / (2 * F100_HZ));
   localparam logic [5:0] HALF_10N = 6'(CLK_HZ / (2 * F10N_HZ));
   localparam logic [5:0] HALF_10S = 6'(CLK_HZ / (2 * F10S_HZ));

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] TXCNT_OFS  = 8'h08;
   localparam logic [7:0] RXCNT_OFS  = 8'h0c;

   localparam int CTRL_SPEED_BIT  = 0;
   localparam int CTRL_SERIAL_BIT = 1;
   localparam int CTRL_SYMN_BIT   = 2;
   localparam logic CTRL_SPEED_RST  = 1'b1;
   localparam logic CTRL_SERIAL_RST = 1'b0;
   localparam logic CTRL_SYMN_RST   = 1'b1;

   localparam int ST_OVF_BIT   = 0;
   localparam int ST_CERR_BIT  = 1;
   localparam int ST_RXEN_BIT  = 2;
   localparam int ST_LEVEL_LSB = 8;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // Code groups and buffering
   localparam logic [4:0] HALT_CODE  = 5'h04;
   localparam int         FIFO_W     = 8;
   localparam int         FIFO_DEPTH = 32;

   typedef enum logic [2:0] {
      LM_100 = 3'h1,
      LM_10N = 3'h2,
      LM_10S = 3'h4
   } link_mode_t;

endpackage

// *** rtl/fifo_buf.sv ***
`timescale 1ns/1ns
`default_nettype none
module fifo_buf
   import mii_phy_pkg::*;
#(
   parameter int W     = FIFO_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic                       clk,
   input  wire logic                       srst,
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [W-1:0]               in_data,
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic [W-1:0]                    out_data,
   output logic [$clog2(DEPTH):0]          level
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wr_ptr;
      logic [AW:0] rd_ptr;
   } fifo_st_t;

   fifo_st_t   s_reg;
   fifo_st_t   s_next;
   logic [W-1:0] mem [DEPTH];
   logic       push;
   logic       pop;

   // ==========================================================
   // Pointers carry one extra bit to tell full from empty
   assign level     = s_reg.wr_ptr - s_reg.rd_ptr;
   assign in_ready  = (level != (AW+1)'(DEPTH));
   assign out_valid = (s_reg.wr_ptr != s_reg.rd_ptr);
   assign out_data  = mem[s_reg.rd_ptr[AW-1:0]];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      s_next = s_reg;
      if (push) begin
         s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
      end
      if (pop) begin
         s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[s_reg.wr_ptr[AW-1:0]] <= in_data;
      end
   end
endmodule // fifo_buf
`default_nettype wire

// *** rtl/mii_data_port.sv ***
// Contract
// - Transmit clock is 25 MHz at 100 Mb/s, 2.5 MHz in 10 Mb/s nibble mode.
// - Transmit clock is 10 MHz in 10 Mb/s serial mode.
// - Nibble transmit data accepted at 2.5 MHz or 25 MHz.
// - Serial mode takes transmit data from bit 0 only.
// - At 100 Mb/s, error plus enable sends HALT instead of the nibble.
// - At 10 Mb/s the transmit error input is ignored.
// - Raw code mode uses transmit error as code bit 4.
// - Receive clock is 25 MHz, 2.5 MHz or 10 MHz by mode.
// - Receive nibble changes on falling receive clock edge.
// - Serial receive data on bit 0 at falling edge, bits 3..1 don't care.
// - Receive outputs float while receive enable low, driven while high.
// - At 100 Mb/s, invalid code group inside packet raises receive error.
// - Raw code mode uses receive error as code bit 4.
// - Receive data valid marks valid data, updated on falling edge.
`timescale 1ns/1ns
`default_nettype none
module mii_data_port
   import mii_phy_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   // AXI4-Lite slave
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // MII pins
   output logic             tx_clk,
   input  wire logic [3:0]  txd,
   input  wire logic        tx_en,
   input  wire logic        tx_er,
   input  wire logic        rx_en,
   output logic             rx_clk_o,
   output logic             rx_clk_oe,
   output logic [3:0]       rxd_o,
   output logic             rxd_oe,
   output logic             rx_dv_o,
   output logic             rx_dv_oe,
   output logic             rx_er_o,
   output logic             rx_er_oe,
   // Line side: transmit items out of the buffer
   output logic             line_tx_valid,
   input  wire logic        line_tx_ready,
   output logic [7:0]       line_tx_data,
   // Line side: receive items, taken once per receive clock
   input  wire logic        line_rx_valid,
   input  wire logic [4:0]  line_rx_data,
   input  wire logic        line_rx_dv,
   output logic             line_rx_ready
);

   // ==========================================================
   // State
   typedef struct packed {
      logic        speed100;
      logic        serial;
      logic        symbol_n;
      logic [5:0]  div_cnt;
      logic        lclk;
      logic [3:0]  txd_m;
      logic [3:0]  txd_s;
      logic        txen_m;
      logic        txen_s;
      logic        txer_m;
      logic        txer_s;
      logic        rxen_m;
      logic        rxen_s;
      logic [3:0]  rxd;
      logic        rx_dv;
      logic        rx_er;
      logic        ovf;
      logic        cerr;
      logic [31:0] tx_cnt;
      logic [31:0] rx_cnt;
      logic        aw_ok;
      logic [7:0]  aw_addr;
      logic        w_ok;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } st_t;

   localparam st_t ST_RST = '{
      speed100: CTRL_SPEED_RST,
      serial:   CTRL_SERIAL_RST,
      symbol_n: CTRL_SYMN_RST,
      default:  '0
   };

   st_t        s_reg;
   st_t        s_next;

   // ==========================================================
   // 4B/5B code groups
   function automatic logic [4:0] enc4b5b(input logic [3:0] n);
      logic [4:0] c;
      c = 5'h00;
      case (n)
         4'h0: c = 5'h1e;
         4'h1: c = 5'h09;
         4'h2: c = 5'h14;
         4'h3: c = 5'h15;
         4'h4: c = 5'h0a;
         4'h5: c = 5'h0b;
         4'h6: c = 5'h0e;
         4'h7: c = 5'h0f;
         4'h8: c = 5'h12;
         4'h9: c = 5'h13;
         4'ha: c = 5'h16;
         4'hb: c = 5'h17;
         4'hc: c = 5'h1a;
         4'hd: c = 5'h1b;
         4'he: c = 5'h1c;
         default: c = 5'h1d;
      endcase
      return c;
   endfunction

   // Returns {valid, nibble}; anything but a data group is invalid
   function automatic logic [4:0] dec5b4b(input logic [4:0] c);
      logic [4:0] r;
      r = 5'h00;
      case (c)
         5'h1e: r = 5'h10;
         5'h09: r = 5'h11;
         5'h14: r = 5'h12;
         5'h15: r = 5'h13;
         5'h0a: r = 5'h14;
         5'h0b: r = 5'h15;
         5'h0e: r = 5'h16;
         5'h0f: r = 5'h17;
         5'h12: r = 5'h18;
         5'h13: r = 5'h19;
         5'h16: r = 5'h1a;
         5'h17: r = 5'h1b;
         5'h1a: r = 5'h1c;
         5'h1b: r = 5'h1d;
         5'h1c: r = 5'h1e;
         5'h1d: r = 5'h1f;
         default: r = 5'h00;
      endcase
      return r;
   endfunction

   function automatic logic byte_hit(input logic [7:0] a, input logic [7:0] ofs);
      return {a[7:2], 2'b00} == ofs;
   endfunction

   // ==========================================================
   // Transmit buffer
   link_mode_t mode;
   logic       raw;
   logic [5:0] half;
   logic       edge_hit;
   logic       rise;
   logic       fall;
   logic       push;
   logic [7:0] push_data;
   logic       fifo_in_ready;
   logic [5:0] fifo_level;
   logic [4:0] dec;
   logic [31:0] rd_word;
   logic [1:0]  rd_resp;

   fifo_buf #(
      .W     (FIFO_W),
      .DEPTH (FIFO_DEPTH)
   ) fifo_buf_inst (
      .clk       (clk),
      .srst      (srst),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (push_data),
      .out_valid (line_tx_valid),
      .out_ready (line_tx_ready),
      .out_data  (line_tx_data),
      .level     (fifo_level)
   );

   always_comb begin
      if (s_reg.speed100) begin
         mode = LM_100;
      end else if (s_reg.serial) begin
         mode = LM_10S;
      end else begin
         mode = LM_10N;
      end
   end

   // Raw code mode only has meaning on the 100 Mb/s path
   assign raw = ~s_reg.symbol_n & (mode == LM_100);

   always_comb begin
      case (mode)
         LM_100:  half = HALF_100;
         LM_10S:  half = HALF_10S;
         default: half = HALF_10N;
      endcase
   end

   // >= rather than == so a mode change mid-count cannot run away
   assign edge_hit = (s_reg.div_cnt >= half - 6'h01);
   assign rise     = edge_hit & ~s_reg.lclk;
   assign fall     = edge_hit & s_reg.lclk;

   // ==========================================================
   // Transmit code formation
   always_comb begin
      push_data = 8'h00;
      push      = 1'b0;
      if (raw) begin
         push_data = {LM_100, s_reg.txer_s, s_reg.txd_s};
         push      = rise;
      end else if (mode == LM_100) begin
         push_data = {LM_100, s_reg.txer_s ? HALT_CODE : enc4b5b(s_reg.txd_s)};
         push      = rise & s_reg.txen_s;
      end else if (mode == LM_10S) begin
         push_data = {LM_10S, 4'h0, s_reg.txd_s[0]};
         push      = rise & s_reg.txen_s;
      end else begin
         push_data = {LM_10N, 1'b0, s_reg.txd_s};
         push      = rise & s_reg.txen_s;
      end
   end

   // One receive item is taken per falling edge of the receive clock
   assign line_rx_ready = fall;
   assign dec           = dec5b4b(line_rx_data);

   // ==========================================================
   // Register read mux
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_resp = RESP_OKAY;
      if (byte_hit(s_axi_araddr, CTRL_OFS)) begin
         rd_word[CTRL_SPEED_BIT]  = s_reg.speed100;
         rd_word[CTRL_SERIAL_BIT] = s_reg.serial;
         rd_word[CTRL_SYMN_BIT]   = s_reg.symbol_n;
      end else if (byte_hit(s_axi_araddr, STATUS_OFS)) begin
         rd_word[ST_OVF_BIT]  = s_reg.ovf;
         rd_word[ST_CERR_BIT] = s_reg.cerr;
         rd_word[ST_RXEN_BIT] = s_reg.rxen_s;
         rd_word[ST_LEVEL_LSB +: 6] = fifo_level;
      end else if (byte_hit(s_axi_araddr, TXCNT_OFS)) begin
         rd_word = s_reg.tx_cnt;
      end else if (byte_hit(s_axi_araddr, RXCNT_OFS)) begin
         rd_word = s_reg.rx_cnt;
      end else begin
         rd_resp = RESP_SLVERR;
      end
   end

   assign s_axi_awready = ~s_reg.aw_ok & ~s_reg.bvalid;
   assign s_axi_wready  = ~s_reg.w_ok & ~s_reg.bvalid;
   assign s_axi_arready = ~s_reg.rvalid;

   // ==========================================================
   // Next state
   always_comb begin
      s_next = s_reg;

      // Pin synchronisers
      s_next.txd_m  = txd;
      s_next.txd_s  = s_reg.txd_m;
      s_next.txen_m = tx_en;
      s_next.txen_s = s_reg.txen_m;
      s_next.txer_m = tx_er;
      s_next.txer_s = s_reg.txer_m;
      s_next.rxen_m = rx_en;
      s_next.rxen_s = s_reg.rxen_m;

      // Shared divider for transmit and receive clocks
      if (edge_hit) begin
         s_next.div_cnt = 6'h00;
         s_next.lclk    = ~s_reg.lclk;
      end else begin
         s_next.div_cnt = s_reg.div_cnt + 6'h01;
      end

      if (push & fifo_in_ready) begin
         s_next.tx_cnt = s_reg.tx_cnt + 32'h0000_0001;
      end

      // Receive outputs move only on the falling edge
      if (fall) begin
         if (!line_rx_valid) begin
            s_next.rx_dv = 1'b0;
            s_next.rx_er = 1'b0;
         end else if (raw) begin
            s_next.rxd   = line_rx_data[3:0];
            s_next.rx_er = line_rx_data[4];
            s_next.rx_dv = line_rx_dv;
         end else if (mode == LM_100) begin
            s_next.rxd   = dec[3:0];
            s_next.rx_dv = line_rx_dv;
            s_next.rx_er = line_rx_dv & ~dec[4];
         end else if (mode == LM_10S) begin
            s_next.rxd   = {3'h0, line_rx_data[0]};
            s_next.rx_dv = line_rx_dv;
            s_next.rx_er = 1'b0;
         end else begin
            s_next.rxd   = line_rx_data[3:0];
            s_next.rx_dv = line_rx_dv;
            s_next.rx_er = 1'b0;
         end
         if (line_rx_valid) begin
            s_next.rx_cnt = s_reg.rx_cnt + 32'h0000_0001;
         end
      end

      // Write channel: address and data taken in either order
      if (s_axi_awvalid & s_axi_awready) begin
         s_next.aw_ok   = 1'b1;
         s_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
         s_next.w_ok   = 1'b1;
         s_next.w_data = s_axi_wdata;
         s_next.w_strb = s_axi_wstrb;
      end
      if (s_reg.aw_ok & s_reg.w_ok) begin
         s_next.aw_ok  = 1'b0;
         s_next.w_ok   = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp  = RESP_OKAY;
         if (byte_hit(s_reg.aw_addr, CTRL_OFS)) begin
            if (s_reg.w_strb[0]) begin
               s_next.speed100 = s_reg.w_data[CTRL_SPEED_BIT];
               s_next.serial   = s_reg.w_data[CTRL_SERIAL_BIT];
               s_next.symbol_n = s_reg.w_data[CTRL_SYMN_BIT];
            end
         end else if (byte_hit(s_reg.aw_addr, STATUS_OFS)) begin
            if (s_reg.w_strb[0]) begin
               s_next.ovf  = s_reg.ovf & ~s_reg.w_data[ST_OVF_BIT];
               s_next.cerr = s_reg.cerr & ~s_reg.w_data[ST_CERR_BIT];
            end
         end else if (byte_hit(s_reg.aw_addr, TXCNT_OFS)) begin
            s_next.bresp = RESP_OKAY;
         end else if (byte_hit(s_reg.aw_addr, RXCNT_OFS)) begin
            s_next.bresp = RESP_OKAY;
         end else begin
            s_next.bresp = RESP_SLVERR;
         end
      end
      if (s_reg.bvalid & s_axi_bready) begin
         s_next.bvalid = 1'b0;
      end

      // Sticky flags: a new event wins over a clear in the same cycle
      if (push & ~fifo_in_ready) begin
         s_next.ovf = 1'b1;
      end
      if (fall & line_rx_valid & line_rx_dv & ~raw & (mode == LM_100) & ~dec[4]) begin
         s_next.cerr = 1'b1;
      end

      // Read channel
      if (s_axi_arvalid & s_axi_arready) begin
         s_next.rvalid = 1'b1;
         s_next.rdata  = rd_word;
         s_next.rresp  = rd_resp;
      end else if (s_reg.rvalid & s_axi_rready) begin
         s_next.rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_reg <= ST_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================================
   // Outputs
   assign s_axi_bvalid = s_reg.bvalid;
   assign s_axi_bresp  = s_reg.bresp;
   assign s_axi_rvalid = s_reg.rvalid;
   assign s_axi_rdata  = s_reg.rdata;
   assign s_axi_rresp  = s_reg.rresp;

   assign tx_clk    = s_reg.lclk;
   assign rx_clk_o  = s_reg.lclk;
   assign rxd_o     = s_reg.rxd;
   assign rx_dv_o   = s_reg.rx_dv;
   assign rx_er_o   = s_reg.rx_er;
   // Float the receive group while the enable pin is low
   assign rx_clk_oe = s_reg.rxen_s;
   assign rxd_oe    = s_reg.rxen_s;
   assign rx_dv_oe  = s_reg.rxen_s;
   assign rx_er_oe  = s_reg.rxen_s;

endmodule // mii_data_port
`default_nettype wire

// *** tb/mii_data_port_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
module mii_data_port_checker (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        rx_en,
   input wire logic        rx_clk_o,
   input wire logic        rx_clk_oe,
   input wire logic [3:0]  rxd_o,
   input wire logic        rxd_oe,
   input wire logic        rx_dv_o,
   input wire logic        rx_dv_oe,
   input wire logic        rx_er_o,
   input wire logic        rx_er_oe,
   input wire logic        line_tx_valid,
   input wire logic        line_tx_ready,
   input wire logic [7:0]  line_tx_data,
   input wire logic        line_rx_ready
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   // ==========================================
   // Register bus
   AST_B_BLOCKS: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
   AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
      && !s_axi_arready) else $error("read not answered next cycle");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped");

   // ==========================================
   // Receive pins and line side
   AST_OE_OFF: assert property (!rx_en [*3] |-> !(rxd_oe | rx_clk_oe | rx_dv_oe | rx_er_oe))
      else $error("receive pins driven while disabled");
   AST_OE_ON: assert property ((rx_en && !srst) [*3] |->
      rxd_oe && rx_clk_oe && rx_dv_oe && rx_er_oe)
      else $error("receive pins floating while enabled");
   AST_RX_FALL: assert property ($changed({rxd_o, rx_dv_o, rx_er_o}) |-> $fell(rx_clk_o))
      else $error("receive outputs moved off the falling clock");
   AST_TAKE_FALL: assert property (line_rx_ready |=> $fell(rx_clk_o))
      else $error("receive item taken off the falling clock");
   // Shortest half period in any mode is two cycles
   AST_CLK_HALF: assert property ($changed(rx_clk_o) |=> $stable(rx_clk_o))
      else $error("receive clock half period too short");
   AST_TX_HOLD: assert property (line_tx_valid && !line_tx_ready |=> line_tx_valid
      && $stable(line_tx_data)) else $error("buffered item lost");
endmodule // mii_data_port_checker

bind mii_data_port mii_data_port_checker mii_data_port_checker_inst (
   .clk, .srst, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .s_axi_rdata, .rx_en, .rx_clk_o, .rx_clk_oe, .rxd_o, .rxd_oe, .rx_dv_o,
   .rx_dv_oe, .rx_er_o, .rx_er_oe, .line_tx_valid, .line_tx_ready, .line_tx_data,
   .line_rx_ready);
`default_nettype wire

// *** tb/mac_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module mac_model (
   input  wire logic       clk,
   input  wire logic       tx_clk,
   output logic [3:0]      txd,
   output logic            tx_en,
   output logic            tx_er
);
   initial begin
      txd = 4'h0;
      tx_en = 1'b0;
      tx_er = 1'b0;
   end

   // ==========================================
   // Drive in the low phase so the rising edge sees settled pins
   task automatic send(input logic [3:0] d, input logic er, input int n);
      @(negedge tx_clk);
      @(posedge clk);
      txd <= d;
      tx_er <= er;
      tx_en <= 1'b1;
      repeat (n) @(negedge tx_clk);
      @(posedge clk);
      tx_en <= 1'b0;
      tx_er <= ~er;
      txd <= ~d;
   endtask

   // Static levels for raw code mode, enable kept low
   task automatic hold(input logic [3:0] d, input logic er);
      @(posedge clk);
      txd <= d;
      tx_er <= er;
      tx_en <= 1'b0;
   endtask
endmodule // mac_model
`default_nettype wire

// *** tb/tb_mii_data_port.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_mii_data_port
   import mii_phy_pkg::*;
;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic        tx_clk, tx_en, tx_er, rx_en = 1'b1;
   logic [3:0]  txd, rxd_o;
   logic        rx_clk_o, rx_clk_oe, rxd_oe, rx_dv_o, rx_dv_oe, rx_er_o, rx_er_oe;
   logic        line_tx_valid, line_tx_ready = 1'b0;
   logic [7:0]  line_tx_data;
   logic        line_rx_valid = 1'b0, line_rx_dv = 1'b0, line_rx_ready;
   logic [4:0]  line_rx_data = 5'h00;
   int          n_mismatch = 0;
   int          checked = 0;
   int          cyc = 0;

   mii_data_port mii_data_port_inst (
      .clk, .srst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
      .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
      .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .tx_clk, .txd, .tx_en, .tx_er,
      .rx_en, .rx_clk_o, .rx_clk_oe, .rxd_o, .rxd_oe, .rx_dv_o, .rx_dv_oe, .rx_er_o,
      .rx_er_oe, .line_tx_valid, .line_tx_ready, .line_tx_data, .line_rx_valid,
      .line_rx_data, .line_rx_dv, .line_rx_ready);

   mac_model mac_model_inst (.clk, .tx_clk, .txd, .tx_en, .tx_er);

   always #5 clk = ~clk;

   // Whole run needs well under this many cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         results();
      end
   end

   // ==========================================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      // Late ready lets the response hold checks see a stall
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready));
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready));
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // Select a mode, then time both link clocks
   task automatic setm(input logic [31:0] v, input logic [5:0] h);
      time t0;
      wr(CTRL_OFS, v, resp);
      repeat (2) @(posedge tx_clk);
      t0 = $time;
      @(posedge tx_clk);
      chk(32'($time - t0), 32'(20 * h));
      @(posedge rx_clk_o);
      t0 = $time;
      @(posedge rx_clk_o);
      chk(32'($time - t0), 32'(20 * h));
   endtask

   task automatic pop(input logic [7:0] e);
      do @(posedge clk); while (!line_tx_valid);
      chk(32'(line_tx_data), 32'(e));
      line_tx_ready <= 1'b1;
      @(posedge clk);
      line_tx_ready <= 1'b0;
   endtask

   // Released line shows the inverse, not the old item
   task automatic rxi(input logic [4:0] d, input logic dv);
      @(posedge clk);
      line_rx_valid <= 1'b1;
      line_rx_data <= d;
      line_rx_dv <= dv;
      do @(posedge clk); while (!line_rx_ready);
      line_rx_valid <= 1'b0;
      line_rx_data <= ~d;
      line_rx_dv <= ~dv;
      @(posedge clk);
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ==========================================
   // Scenarios
   task automatic t_regs;
      rd(CTRL_OFS, rdat, resp);
      chk(rdat, {29'h0, CTRL_SYMN_RST, CTRL_SERIAL_RST, CTRL_SPEED_RST});
      rd(8'h10, rdat, resp);
      chk(32'(resp), 32'(RESP_SLVERR));
      wr(8'h10, 32'h3, resp);
      chk(32'(resp), 32'(RESP_SLVERR));
      wr(TXCNT_OFS, 32'hffff, resp);
      chk(32'(resp), 32'(RESP_OKAY));
      rd(TXCNT_OFS, rdat, resp);
      chk(rdat, 32'h0);
      $display("registers done");
   endtask

   task automatic t_tx;
      setm(32'h5, HALF_100);
      mac_model_inst.send(4'h3, 1'b1, 1);
      pop({LM_100, HALT_CODE});
      setm(32'h4, HALF_10N);
      mac_model_inst.send(4'h9, 1'b1, 2);
      pop({LM_10N, 5'h09});
      pop({LM_10N, 5'h09});
      setm(32'h6, HALF_10S);
      mac_model_inst.send(4'hd, 1'b1, 1);
      pop({LM_10S, 5'h01});
      mac_model_inst.send(4'he, 1'b0, 1);
      pop({LM_10S, 5'h00});
      $display("transmit done");
   endtask

   task automatic t_fill;
      mac_model_inst.hold(4'ha, 1'b1);
      wr(CTRL_OFS, 32'h1, resp);
      repeat (200) @(posedge clk);
      rd(STATUS_OFS, rdat, resp);
      chk(rdat & 32'h3f01, 32'(FIFO_DEPTH << ST_LEVEL_LSB) | 32'h1);
      pop({LM_100, 5'h1a});
      mac_model_inst.hold(4'h0, 1'b0);
      wr(CTRL_OFS, 32'h5, resp);
      line_tx_ready <= 1'b1;
      repeat (60) @(posedge clk);
      line_tx_ready <= 1'b0;
      wr(STATUS_OFS, 32'h1, resp);
      rd(STATUS_OFS, rdat, resp);
      chk(rdat & 32'h3f01, 32'h0);
      $display("buffer done");
   endtask

   task automatic t_rx;
      wr(CTRL_OFS, 32'h1, resp);
      // Valid flag has no meaning here, left unjudged
      rxi(5'h17, 1'b1);
      chk(32'({rx_er_o, rxd_o}), 32'h17);
      wr(CTRL_OFS, 32'h5, resp);
      rxi(HALT_CODE, 1'b1);
      chk(32'({rx_dv_o, rx_er_o}), 32'h3);
      rxi(HALT_CODE, 1'b0);
      chk(32'(rx_er_o), 32'h0);
      rd(STATUS_OFS, rdat, resp);
      chk(32'(rdat[ST_CERR_BIT]), 32'h1);
      wr(CTRL_OFS, 32'h6, resp);
      rxi(5'h03, 1'b1);
      chk(32'({rx_dv_o, rxd_o[0]}), 32'h3);
      rxi(5'h02, 1'b1);
      chk(32'(rxd_o[0]), 32'h0);
      repeat (15) @(posedge clk);
      chk(32'(rx_dv_o), 32'h0);
      rd(RXCNT_OFS, rdat, resp);
      chk(rdat, 32'h5);
      $display("receive done");
   endtask

   task automatic t_oe;
      @(posedge clk);
      rx_en <= 1'b0;
      repeat (5) @(posedge clk);
      chk(32'({rxd_oe, rx_clk_oe, rx_dv_oe, rx_er_oe}), 32'h0);
      rx_en <= 1'b1;
      repeat (5) @(posedge clk);
      chk(32'({rxd_oe, rx_clk_oe, rx_dv_oe, rx_er_oe}), 32'hf);
      $display("receive enable done");
   endtask

   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      t_regs();
      t_tx();
      t_fill();
      t_rx();
      t_oe();
      results();
   end
endmodule // tb_mii_data_port
`default_nettype wire
